/* File: rtl/pvs_consts.svh */
// Constants of the parallel video source that drives the pixel input port
`ifndef PVS_CONSTS_SVH
`define PVS_CONSTS_SVH

`define PVS_CLK_NS          20
`define PVS_CLK_PS          20000
`define PVS_RST_LOW_NS      1250
`define PVS_RST_CYC         ((`PVS_RST_LOW_NS + `PVS_CLK_NS - 1) / `PVS_CLK_NS)
`define PVS_STEREO_NS       1000000
`define PVS_STEREO_CYC      ((`PVS_STEREO_NS + `PVS_CLK_NS - 1) / `PVS_CLK_NS)

`define PVS_V_SYNC_MIN      1
`define PVS_V_BP_MIN        2
`define PVS_V_FP_MIN        1
`define PVS_TVB_BASE        6
`define PVS_TVB_MULT        8
`define PVS_H_SYNC_MIN      4
`define PVS_H_SYNC_MAX      128
`define PVS_H_BP_MIN        4
`define PVS_H_FP_MIN        8
`define PVS_POS_MAX         4095

`define PVS_PAR_PER_MIN_PS  6450
`define PVS_BT_PER_MIN_PS   29850
`define PVS_PER_MAX_PS      1000000

`define PVS_BT_CODE_LEN     4
`define PVS_BT_FF           8'hFF
`define PVS_BT_00           8'h00
`define PVS_BT_BLANK_C      8'h80
`define PVS_BT_BLANK_Y      8'h10

`endif

/* File: rtl/pvs_pclk_div.sv */
// Pixel clock divider with a tick on each falling pixel clock edge
`timescale 1ns/1ps
module pvs_pclk_div #(
  parameter int DIV = 8
) (
  input  wire logic clk_in,
  input  wire logic rst_b_in,
  output logic      pclk_out,
  output logic      fall_tick_out
);
  import pvs_pkg::*;

  localparam logic [7:0] LAST = 8'(DIV - 1);
  localparam logic [7:0] HALF = 8'(DIV / 2 - 1);

  if (DIV < 2 || DIV > 256 || (DIV % 2) != 0) begin : g_bad_div
    $error("pvs_pclk_div: DIV must be even and in 2..256");
  end

  pvs_div_s q;
  pvs_div_s d;

  always_comb begin
    d = q;
    d.tick = 1'b0;
    if (q.cnt == LAST) begin
      d.cnt = 8'h00;
      d.pclk = 1'b0;
      d.tick = 1'b1;
    end else begin
      d.cnt = q.cnt + 8'h01;
      if (q.cnt == HALF) begin
        d.pclk = 1'b1;
      end
    end
  end

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign pclk_out      = q.pclk;
  assign fall_tick_out = q.tick;

endmodule

/* File: rtl/pvs_pkg.sv */
// Types shared by the parallel video source modules
package pvs_pkg;

  typedef enum logic [1:0] {
    PVS_CHIP_RST,
    PVS_IDLE,
    PVS_RUN
  } pvs_state_e;

  typedef struct packed {
    logic [7:0] cnt;
    logic       pclk;
    logic       tick;
  } pvs_div_s;

  typedef struct packed {
    pvs_state_e  st;
    logic [6:0]  rst_cnt;
    logic [11:0] h;
    logic [11:0] v;
    logic        bt;
    logic [31:0] since;
    logic        fs;
    logic        ls;
    logic        de;
    logic [23:0] word;
    logic        stereo;
    logic        chip_rst_n;
    logic        take;
    logic        fstart;
    logic        run;
  } pvs_src_s;

endpackage

/* File: rtl/pvs_source.sv */
// Video source that drives the parallel pixel input port of the device
`timescale 1ns/1ps
`include "pvs_consts.svh"
module pvs_source #(
  parameter int PCLK_DIV            = 8,
  parameter int H_ACT               = 640,
  parameter int H_SYNC              = 4,
  parameter int H_BP                = 8,
  parameter int H_FP                = 8,
  parameter int SOURCE_ACTIVE_LINES = 480,
  parameter int ARRAY_USED_LINES    = 480,
  parameter int V_SYNC              = 1,
  parameter int V_BP                = 8,
  parameter int V_FP                = 6,
  parameter int STEREO_CYC          = `PVS_STEREO_CYC
) (
  input  wire logic        clk_in,
  input  wire logic        rst_b_in,
  input  wire logic        enable_in,
  input  wire logic        bt656_mode_in,
  input  wire logic        reset_req_in,
  input  wire logic        stereo_req_in,
  input  wire logic [23:0] pixel_data_in,
  output logic             pixel_clock_out,
  output logic             frame_sync_out,
  output logic             line_sync_out,
  output logic             pixel_valid_out,
  output logic [23:0]      pixel_word_bus_out,
  output logic             stereo_frame_flag_out,
  output logic             chip_reset_low_out,
  output logic             pixel_take_out,
  output logic             frame_start_out,
  output logic             running_out
);
  import pvs_pkg::*;

  localparam int H_TOT_I = H_BP + H_ACT + H_FP;
  localparam int V_TOT_I = V_BP + SOURCE_ACTIVE_LINES + V_FP;
  localparam int RATIO_I = (SOURCE_ACTIVE_LINES + ARRAY_USED_LINES - 1) / ARRAY_USED_LINES;
  localparam int TVB_MIN = `PVS_TVB_BASE + `PVS_TVB_MULT * ((RATIO_I > 1) ? RATIO_I : 1);
  localparam longint PCLK_PS = longint'(PCLK_DIV) * `PVS_CLK_PS;
  localparam longint FALL_TO_RISE = longint'(V_TOT_I - V_SYNC) * H_TOT_I * PCLK_DIV;

  localparam logic [11:0] H_TOT  = 12'(H_TOT_I);
  localparam logic [11:0] V_TOT  = 12'(V_TOT_I);
  localparam logic [11:0] HS_LEN = 12'(H_SYNC);
  localparam logic [11:0] HB     = 12'(H_BP);
  localparam logic [11:0] HA     = 12'(H_ACT);
  localparam logic [11:0] VS_LEN = 12'(V_SYNC);
  localparam logic [11:0] VB     = 12'(V_BP);
  localparam logic [11:0] VA     = 12'(SOURCE_ACTIVE_LINES);
  localparam logic [11:0] CODE_N = 12'(`PVS_BT_CODE_LEN);
  localparam logic [6:0]  RST_LAST   = 7'(`PVS_RST_CYC - 1);
  localparam logic [31:0] STEREO_HIT = 32'(STEREO_CYC);

  if (H_SYNC < `PVS_H_SYNC_MIN) begin : g_bad_hs_min
    $error("pvs_source: H_SYNC below the line sync minimum");
  end
  if (H_SYNC > `PVS_H_SYNC_MAX) begin : g_bad_hs_max
    $error("pvs_source: H_SYNC above the line sync maximum");
  end
  if (H_SYNC > H_BP) begin : g_bad_hs_bp
    $error("pvs_source: H_SYNC longer than H_BP");
  end

  if (H_BP < `PVS_H_BP_MIN) begin : g_bad_hbp
    $error("pvs_source: horizontal back porch too short");
  end
  if (H_FP < `PVS_H_FP_MIN) begin : g_bad_hfp
    $error("pvs_source: horizontal front porch too short");
  end
  if (H_ACT < 1) begin : g_bad_hact
    $error("pvs_source: H_ACT must be at least one pixel");
  end

  if (V_SYNC < `PVS_V_SYNC_MIN) begin : g_bad_vs_min
    $error("pvs_source: V_SYNC below one line");
  end
  if (V_SYNC > V_BP) begin : g_bad_vs_bp
    $error("pvs_source: V_SYNC longer than V_BP");
  end
  if (SOURCE_ACTIVE_LINES < 1) begin : g_bad_vact
    $error("pvs_source: SOURCE_ACTIVE_LINES must be at least one");
  end

  if (V_BP < `PVS_V_BP_MIN) begin : g_bad_vbp
    $error("pvs_source: vertical back porch too short");
  end
  if (V_FP < `PVS_V_FP_MIN) begin : g_bad_vfp
    $error("pvs_source: vertical front porch too short");
  end
  if (V_BP + V_FP < TVB_MIN) begin : g_bad_tvb
    $error("pvs_source: total vertical blanking too short");
  end

  if (ARRAY_USED_LINES < 1) begin : g_bad_used
    $error("pvs_source: ARRAY_USED_LINES must be at least one");
  end
  if (H_TOT_I > `PVS_POS_MAX) begin : g_bad_htot
    $error("pvs_source: line too long for the position counter");
  end
  if (V_TOT_I > `PVS_POS_MAX) begin : g_bad_vtot
    $error("pvs_source: frame too tall for the position counter");
  end

  if (PCLK_PS < `PVS_BT_PER_MIN_PS || PCLK_PS > `PVS_PER_MAX_PS) begin : g_bad_pclk
    $error("pvs_source: pixel clock period out of range");
  end

  if (STEREO_CYC < 1) begin : g_bad_st_min
    $error("pvs_source: STEREO_CYC must be at least one");
  end
  if (FALL_TO_RISE < 2 * longint'(STEREO_CYC) + 2) begin : g_bad_st_fit
    $error("pvs_source: frame too short for stereo flag setup and hold");
  end

  // Position p lies in [lo, lo+len)
  function automatic logic in_win(input logic [11:0] p,
                                  input logic [11:0] lo,
                                  input logic [11:0] len);
    return (p >= lo) && (p < 12'(lo + len));
  endfunction

  // BT.656 status byte: fixed 1, field 0, V, H and protection bits
  function automatic logic [7:0] bt_xy(input logic vb, input logic eav);
    return {1'b1, 1'b0, vb, eav, vb ^ eav, eav, vb, vb ^ eav};
  endfunction

  function automatic logic [7:0] bt_code(input logic [11:0] idx, input logic [7:0] xy);
    logic [7:0] b;
    b = xy;
    if (idx == 12'h000) begin
      b = `PVS_BT_FF;
    end else if (idx != 12'(`PVS_BT_CODE_LEN - 1)) begin
      b = `PVS_BT_00;
    end
    return b;
  endfunction

  logic     tick;
  logic     pclk;
  pvs_src_s q;
  pvs_src_s d;

  // Outputs launch one clock after the pixel clock falls (a reset request clears them on any clock, a stop clears the word one clock later),
  // so with PCLK_DIV of 6 or more they are settled before the rising sampling edge
  pvs_pclk_div #(
    .DIV (PCLK_DIV)
  ) u_div (
    .clk_in        (clk_in),
    .rst_b_in      (rst_b_in),
    .pclk_out      (pclk),
    .fall_tick_out (tick)
  );

  always_comb begin
    logic        act_line;
    logic        act_px;
    logic        in_sav;
    logic        in_eav;
    logic        last_h;
    logic [11:0] sav_lo;
    logic [11:0] eav_lo;
    logic [7:0]  bt_byte;
    act_line = 1'b0;
    act_px   = 1'b0;
    in_sav   = 1'b0;
    in_eav   = 1'b0;
    last_h   = 1'b0;
    sav_lo   = HB - CODE_N;
    eav_lo   = HB + HA;
    bt_byte  = 8'h00;
    d = q;
    d.take = 1'b0;
    d.fstart = 1'b0;

    // Hold counter from the last frame sync fall; saturates
    if (q.st == PVS_RUN && tick && q.h == 12'h000 && q.v == VS_LEN) begin
      d.since = 32'h0000_0000;
    end else if (q.since != STEREO_HIT) begin
      d.since = q.since + 32'h0000_0001;
    end
    // Flag moves only here: hold after the fall is met, and the
    // geometry check keeps the next rise a full setup away
    if (q.st == PVS_RUN && q.since == STEREO_HIT - 32'h0000_0001) begin
      d.stereo = stereo_req_in;
    end

    if (reset_req_in) begin
      // Saturate so a restarted frame cannot move the flag early
      d.since = STEREO_HIT;
      d.st = PVS_CHIP_RST;
      d.rst_cnt = 7'h00;
      d.chip_rst_n = 1'b0;
      d.fs = 1'b0;
      d.ls = 1'b0;
      d.de = 1'b0;
      d.word = 24'h000000;
    end else begin
      unique case (q.st)
        PVS_CHIP_RST: begin
          if (q.rst_cnt == RST_LAST) begin
            d.chip_rst_n = 1'b1;
            d.st = PVS_IDLE;
          end else begin
            d.rst_cnt = q.rst_cnt + 7'h01;
          end
        end
        PVS_IDLE: begin
          if (tick && enable_in) begin
            d.st = PVS_RUN;
            d.h = 12'h000;
            d.v = 12'h000;
            d.bt = bt656_mode_in;
          end
        end
        PVS_RUN: begin
          if (tick) begin
            act_line = in_win(q.v, VB, VA);
            act_px = act_line && in_win(q.h, HB, HA);
            in_sav = in_win(q.h, sav_lo, CODE_N);
            in_eav = in_win(q.h, eav_lo, CODE_N);
            last_h = (q.h == H_TOT - 12'h001);
            d.fstart = (q.h == 12'h000) && (q.v == 12'h000);
            if (q.bt) begin
              // Sync rides in the byte stream; separate strobes rest low
              d.fs = 1'b0;
              d.ls = 1'b0;
              d.de = 1'b0;
              if (in_sav) begin
                bt_byte = bt_code(q.h - sav_lo, bt_xy(!act_line, 1'b0));
              end else if (in_eav) begin
                bt_byte = bt_code(q.h - eav_lo, bt_xy(!act_line, 1'b1));
              end else if (act_px) begin
                bt_byte = pixel_data_in[7:0];
              end else if (q.h[0]) begin
                bt_byte = `PVS_BT_BLANK_Y;
              end else begin
                bt_byte = `PVS_BT_BLANK_C;
              end
              d.word = {16'h0000, bt_byte};
              d.take = act_px;
            end else begin
              d.fs = (q.v < VS_LEN);
              d.ls = (q.h < HS_LEN);
              d.de = act_px;
              // Blank word outside the valid window
              d.word = act_px ? pixel_data_in : 24'h000000;
              d.take = act_px;
            end
            if (last_h) begin
              d.h = 12'h000;
              if (q.v == V_TOT - 12'h001) begin
                d.v = 12'h000;
                // Stop only at a frame boundary so porches stay whole
                if (!enable_in) begin
                  d.st = PVS_IDLE;
                end else begin
                  d.bt = bt656_mode_in;
                end
              end else begin
                d.v = q.v + 12'h001;
              end
            end else begin
              d.h = q.h + 12'h001;
            end
          end
        end
        default: begin
          d.st = PVS_CHIP_RST;
          d.rst_cnt = 7'h00;
          d.chip_rst_n = 1'b0;
        end
      endcase
      if (q.st == PVS_IDLE) begin
        d.fs = 1'b0;
        d.ls = 1'b0;
        d.de = 1'b0;
        d.word = 24'h000000;
      end
    end
    d.run = (d.st == PVS_RUN);
  end

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      q <= '{st: PVS_CHIP_RST, since: STEREO_HIT, default: '0};
    end else begin
      q <= d;
    end
  end

  assign pixel_clock_out       = pclk;
  assign frame_sync_out        = q.fs;
  assign line_sync_out         = q.ls;
  assign pixel_valid_out       = q.de;
  assign pixel_word_bus_out    = q.word;
  assign stereo_frame_flag_out = q.stereo;
  assign chip_reset_low_out    = q.chip_rst_n;
  assign pixel_take_out        = q.take;
  assign frame_start_out       = q.fstart;
  assign running_out           = q.run;

endmodule

/* File: test/pvs_dev_model.sv */
// Behavioural pixel input port of the display device
`timescale 1ns/1ps
module pvs_dev_model (
  input  wire logic        pclk_in,
  input  wire logic        frame_sync_in,
  input  wire logic        line_sync_in,
  input  wire logic        pixel_valid_in,
  input  wire logic [23:0] pixel_word_bus_in,
  input  wire logic        chip_reset_low_in,
  output logic [15:0]      pix_out,
  output logic [23:0]      sum_out,
  output logic [23:0]      first_out,
  output logic [7:0]       vbp_out,
  output logic [7:0]       vblank_out,
  output logic [3:0]       codes_out,
  output logic [7:0]       bt_bytes_out,
  output logic [31:0]      rst_ns_out
);
  logic        fs_p, ls_p, had, seen, in_act;
  logic [15:0] pix;
  logic [23:0] sum, first;
  logic [7:0]  bp, blank, nb, b;
  logic [31:0] sh;
  realtime     t_low;
  always @(negedge chip_reset_low_in) t_low = $realtime;
  always @(posedge chip_reset_low_in) rst_ns_out = 32'($rtoi($realtime - t_low));
  // Line counts close at each line sync rise, frame totals latch at the frame sync rise
  always @(posedge pclk_in or negedge chip_reset_low_in) begin
    if (!chip_reset_low_in) begin
      {fs_p, ls_p, had, seen, in_act, pix, sum, bp, blank, nb, sh, codes_out} = '0;
    end else begin
      if (line_sync_in && !ls_p) begin
        if (!had) blank = blank + 8'h01;
        if (!seen) bp = bp + 8'h01;
        had = 1'b0;
      end
      if (frame_sync_in && !fs_p) begin
        {pix_out, sum_out, first_out, vbp_out, vblank_out} = {pix, sum, first, bp, blank};
        {pix, sum, bp, blank, seen} = '0;
      end
      if (pixel_valid_in) begin
        if (pix == 16'h0) first = pixel_word_bus_in;
        pix = pix + 16'h1;
        sum = sum + pixel_word_bus_in;
        {had, seen} = 2'b11;
      end
      sh = {sh[23:0], pixel_word_bus_in[7:0]};
      b = sh[7:0];
      if (sh[31:8] == 24'hFF0000) begin
        codes_out = codes_out | {b == 8'hB6, b == 8'hAB, b == 8'h9D, b == 8'h80};
        in_act = (b == 8'h80);
        nb = 8'h00;
      end else if (in_act && b == 8'hFF) begin
        in_act = 1'b0;
        bt_bytes_out = nb;
      end else if (in_act) begin
        nb = nb + 8'h01;
      end
      fs_p = frame_sync_in;
      ls_p = line_sync_in;
    end
  end
endmodule

/* File: test/pvs_source_monitor.sv */
// Concurrent checks on the pixel link driven by the video source
`timescale 1ns/1ps
module pvs_source_monitor #(
  parameter int PCLK_DIV   = 8,
  parameter int STEREO_CYC = 200
) (
  input wire logic        clk_in,
  input wire logic        rst_b_in,
  input wire logic        pixel_clock_out,
  input wire logic        frame_sync_out,
  input wire logic        line_sync_out,
  input wire logic        pixel_valid_out,
  input wire logic [23:0] pixel_word_bus_out,
  input wire logic        stereo_frame_flag_out,
  input wire logic        chip_reset_low_out
);
  int lo_q, fs_q, st_q, lsh_q, lsa_q, dea_q;
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!rst_b_in);
  // The fs_q, st_q and dea_q ages start large so the first frame after reset is not judged
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      lo_q  <= 0;
      fs_q  <= 999999;
      st_q  <= 999999;
      lsh_q <= 0;
      lsa_q <= 0;
      dea_q <= 999999;
    end else begin
      lo_q  <= chip_reset_low_out ? 0 : lo_q + 1;
      fs_q  <= $changed(frame_sync_out) ? 1 : fs_q + 1;
      st_q  <= $changed(stereo_frame_flag_out) ? 1 : st_q + 1;
      lsh_q <= line_sync_out ? lsh_q + 1 : 0;
      lsa_q <= $rose(line_sync_out) ? 1 : lsa_q + 1;
      // An aborted line does not count as a front porch
      dea_q <= !chip_reset_low_out ? 999999 : $fell(pixel_valid_out) ? 1 : dea_q + 1;
    end
  end
  property p_rst_width;
    $rose(chip_reset_low_out) |-> lo_q >= 63;
  endproperty
  a_rst_width: assert property (p_rst_width) else $error("reset pulse short");
  property p_fs_width;
    $fell(frame_sync_out) && chip_reset_low_out |-> $rose(line_sync_out) && fs_q >= lsa_q;
  endproperty
  a_fs_width: assert property (p_fs_width) else $error("frame sync short");
  property p_ls_width;
    $fell(line_sync_out) && chip_reset_low_out |-> lsh_q inside {[4*PCLK_DIV:128*PCLK_DIV]};
  endproperty
  a_ls_width: assert property (p_ls_width) else $error("line sync width");
  property p_hbp;
    $rose(pixel_valid_out) |-> lsa_q >= 4 * PCLK_DIV;
  endproperty
  a_hbp: assert property (p_hbp) else $error("back porch short");
  property p_hfp;
    $rose(line_sync_out) |-> dea_q >= 8 * PCLK_DIV;
  endproperty
  a_hfp: assert property (p_hfp) else $error("front porch short");
  property p_launch;
    $changed({line_sync_out, pixel_valid_out, pixel_word_bus_out}) && chip_reset_low_out
      |-> !pixel_clock_out && $stable(pixel_clock_out);
  endproperty
  a_launch: assert property (p_launch) else $error("link change near clock rise");
  property p_st_setup;
    $changed(frame_sync_out) && chip_reset_low_out |-> st_q >= STEREO_CYC;
  endproperty
  a_st_setup: assert property (p_st_setup) else $error("stereo setup short");
  property p_st_hold;
    $changed(stereo_frame_flag_out) |-> fs_q >= STEREO_CYC;
  endproperty
  a_st_hold: assert property (p_st_hold) else $error("stereo hold short");
endmodule

bind pvs_source pvs_source_monitor #(.PCLK_DIV(PCLK_DIV), .STEREO_CYC(STEREO_CYC)) i_mon (
  .clk_in(clk_in), .rst_b_in(rst_b_in), .pixel_clock_out(pixel_clock_out),
  .frame_sync_out(frame_sync_out), .line_sync_out(line_sync_out),
  .pixel_valid_out(pixel_valid_out), .pixel_word_bus_out(pixel_word_bus_out),
  .stereo_frame_flag_out(stereo_frame_flag_out), .chip_reset_low_out(chip_reset_low_out)
);

/* File: test/pvs_source_tb.sv */
// Self-checking bench for the parallel video source
`timescale 1ns/1ps
module pvs_source_tb;
  localparam int FR = 2880;
  logic        clk_in, rst_b_in, enable_in, bt656_mode_in, reset_req_in, stereo_req_in;
  logic [23:0] pixel_data_in, word, sum, first;
  logic        pclk, fs, ls, de, st, chip, take, fstart, run;
  logic [15:0] pix;
  logic [7:0]  vbp, vblank, bt_bytes;
  logic [3:0]  codes;
  logic [31:0] rst_ns;
  int          err_count, num_checks;
  // Small geometry keeps a frame at 2880 clocks
  pvs_source #(.H_ACT(8), .H_BP(4), .SOURCE_ACTIVE_LINES(4), .ARRAY_USED_LINES(4),
    .STEREO_CYC(200)) i_dut (
    .clk_in(clk_in), .rst_b_in(rst_b_in), .enable_in(enable_in),
    .bt656_mode_in(bt656_mode_in), .reset_req_in(reset_req_in),
    .stereo_req_in(stereo_req_in), .pixel_data_in(pixel_data_in),
    .pixel_clock_out(pclk), .frame_sync_out(fs), .line_sync_out(ls),
    .pixel_valid_out(de), .pixel_word_bus_out(word), .stereo_frame_flag_out(st),
    .chip_reset_low_out(chip), .pixel_take_out(take), .frame_start_out(fstart),
    .running_out(run));
  pvs_dev_model i_dev (
    .pclk_in(pclk), .frame_sync_in(fs), .line_sync_in(ls), .pixel_valid_in(de),
    .pixel_word_bus_in(word), .chip_reset_low_in(chip), .pix_out(pix), .sum_out(sum),
    .first_out(first), .vbp_out(vbp), .vblank_out(vblank), .codes_out(codes),
    .bt_bytes_out(bt_bytes), .rst_ns_out(rst_ns));
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic complete_run;
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic wait_frames(input int n);
    int i;
    repeat (n) begin
      i = 0;
      do begin
        @(posedge clk_in);
        i++;
      end while (fstart !== 1'b1 && i < 4000);
      check(i < 4000, 1);
    end
    repeat (10) @(posedge clk_in);
  endtask
  task automatic t_par;
    enable_in <= 1'b1;
    wait_frames(3);
    check(pix, 32);
    check(vbp, 8);
    check(vblank, 6 + 8);
    check(vblank - vbp, 6);
    check(sum, 24'((first << 5) + 496));
  endtask
  task automatic t_stereo;
    stereo_req_in <= 1'b1;
    wait_frames(2);
    check(st, 1);
    stereo_req_in <= 1'b0;
    wait_frames(2);
    check(st, 0);
  endtask
  task automatic t_bt;
    bt656_mode_in <= 1'b1;
    @(posedge clk_in);
    pixel_data_in <= 24'h00005A;
    repeat (3 * FR) @(posedge clk_in);
    check(codes, 4'hF);
    check(bt_bytes, 8);
    check({fs, ls, de, word[23:8]}, 0);
    bt656_mode_in <= 1'b0;
  endtask
  task automatic t_reset_req;
    repeat (300) @(posedge clk_in);
    reset_req_in <= 1'b1;
    @(posedge clk_in);
    reset_req_in <= 1'b0;
    repeat (2) @(posedge clk_in);
    check({chip, fs, ls, de, word}, 0);
    repeat (70) @(posedge clk_in);
    check(chip, 1);
    check(rst_ns, 1260);
  endtask
  // Stands in for the user logic: next word follows each take outside BT.656 mode
  always @(posedge clk_in) if (take === 1'b1 && !bt656_mode_in) pixel_data_in <= pixel_data_in + 24'h1;
  initial begin
    clk_in = 1'b0;
    forever #10 clk_in = ~clk_in;
  end
  initial begin
    #1400000;
    err_count++;
    complete_run;
  end
  initial begin
    {rst_b_in, enable_in, bt656_mode_in, reset_req_in, stereo_req_in} = '0;
    pixel_data_in = 24'h123456;
    repeat (5) @(posedge clk_in);
    rst_b_in <= 1'b1;
    repeat (70) @(posedge clk_in);
    check(chip, 1);
    check(rst_ns >= 1250, 1);
    t_par;
    t_stereo;
    t_bt;
    t_par;
    t_reset_req;
    t_par;
    enable_in <= 1'b0;
    repeat (FR + 100) @(posedge clk_in);
    check({run, de}, 0);
    complete_run;
  end
endmodule
